// file: shared/evu_pkg.sv
package evu_pkg;
  // Register byte addresses (printed offsets are indices, not multiples of 4)
  localparam logic [7:0] EVU_IDX_CFI        = 8'h1B;
  localparam logic [7:0] EVU_IDX_ERPC       = 8'h1E;
  localparam logic [11:0] EVU_ADDR_CFI      = {2'h0, EVU_IDX_CFI, 2'h0};
  localparam logic [11:0] EVU_ADDR_ERPC_LO  = {2'h0, EVU_IDX_ERPC, 2'h0};
  localparam logic [11:0] EVU_ADDR_ERPC_HI  = 12'h07C;
  localparam logic [11:0] EVU_ADDR_STATUS   = 12'h100;
  localparam logic [11:0] EVU_ADDR_CAUSE    = 12'h104;
  localparam logic [11:0] EVU_ADDR_EPC_LO   = 12'h108;
  localparam logic [11:0] EVU_ADDR_EPC_HI   = 12'h10C;
  localparam logic [11:0] EVU_ADDR_VEC_LO   = 12'h110;
  localparam logic [11:0] EVU_ADDR_VEC_HI   = 12'h114;
  localparam logic [11:0] EVU_ADDR_PPN      = 12'h118;
  localparam logic [11:0] EVU_ADDR_PPW      = 12'h11C;
  localparam logic [11:0] EVU_ADDR_TLBCNT   = 12'h120;

  // Status bit positions
  localparam int EVU_ST_EXL  = 1;
  localparam int EVU_ST_ERL  = 2;
  localparam int EVU_ST_KSU  = 3;
  localparam int EVU_ST_UX   = 5;
  localparam int EVU_ST_SX   = 6;
  localparam int EVU_ST_KX   = 7;
  localparam int EVU_ST_SR   = 20;
  localparam int EVU_ST_BEV  = 22;
  // Software may also clear the boot vector bit once handlers are in RAM
  localparam logic [31:0] EVU_ST_RW_MASK = 32'h0040_00FB;

  // Cause layout
  localparam int EVU_CA_BD = 31;
  localparam logic [31:0] EVU_CA_IP_MASK = 32'h0000_FF00;
  localparam logic [31:0] EVU_CA_SW_MASK = 32'h0000_0300;

  // Vectors
  localparam logic [63:0] EVU_VEC_RESET    = 64'hFFFF_FFFF_BFC0_0000;
  localparam logic [63:0] EVU_BASE_BOOT    = 64'hFFFF_FFFF_BFC0_0200;
  localparam logic [63:0] EVU_BASE_NORM    = 64'hFFFF_FFFF_8000_0000;
  localparam logic [63:0] EVU_BASE_CERR    = 64'hFFFF_FFFF_A000_0000;
  localparam logic [63:0] EVU_OFF_REFILL   = 64'h0000_0000_0000_0000;
  localparam logic [63:0] EVU_OFF_XREFILL  = 64'h0000_0000_0000_0080;
  localparam logic [63:0] EVU_OFF_CERR     = 64'h0000_0000_0000_0100;
  localparam logic [63:0] EVU_OFF_OTHER    = 64'h0000_0000_0000_0180;

  // Address regions
  localparam logic [63:0] EVU_KSEG3_LO  = 64'hFFFF_FFFF_E000_0000;
  localparam logic [63:0] EVU_SSEG_LO   = 64'hFFFF_FFFF_C000_0000;
  localparam logic [63:0] EVU_USEG_HI   = 64'h0000_0000_7FFF_FFFF;
  localparam logic [63:0] EVU_CMP32_LO  = 64'hFFFF_FFFF_8000_0000;

  // Exception codes
  localparam logic [4:0] EVU_EC_INT  = 5'h00;
  localparam logic [4:0] EVU_EC_MOD  = 5'h01;
  localparam logic [4:0] EVU_EC_TLBL = 5'h02;
  localparam logic [4:0] EVU_EC_TLBS = 5'h03;
  localparam logic [4:0] EVU_EC_ADEL = 5'h04;
  localparam logic [4:0] EVU_EC_ADES = 5'h05;
  localparam logic [4:0] EVU_EC_IBE  = 5'h06;
  localparam logic [4:0] EVU_EC_DBE  = 5'h07;

  // Pending exception requests from the pipeline
  typedef struct packed {
    logic soft_reset;
    logic nmi;
    logic i_addr_err;
    logic i_tlb_refill;
    logic i_tlb_invalid;
    logic i_cache_err;
    logic i_bus_err;
    logic exec_exc;
    logic d_addr_err;
    logic d_tlb_refill;
    logic d_tlb_invalid;
    logic d_tlb_mod;
    logic d_cache_err;
    logic d_bus_err;
    logic interrupt;
  } evu_req_s;

  // Context of the faulting instruction
  typedef struct packed {
    logic [63:0] pc;
    logic [63:0] bad_vaddr;
    logic        in_delay_slot;
    logic        is_store;
    logic [1:0]  coproc_num;
    logic [4:0]  exec_code;
    logic [7:0]  irq_lines;
    logic        eret;
  } evu_ctx_s;

  // Cache fault details
  typedef struct packed {
    logic        ref_kind_flag;
    logic        cache_level_flag;
    logic        data_field_error;
    logic        tag_field_error;
    logic        sysbus_error_flag;
    logic        extra_data_error;
    logic        store_miss_fill_error;
    logic [21:3] phys_index;
    logic [13:12] virt_index_bits;
  } evu_cerr_s;

  typedef enum logic [2:0] {
    EVU_K_NONE, EVU_K_RESET, EVU_K_CERR, EVU_K_REFILL, EVU_K_GEN
  } evu_kind_e;
endpackage

// file: hw/evu_exception_vector_unit.sv
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Load cache fault info on cache error
// - Reference kind, level, data, tag flags
// - Bus, extra data, store miss flags
// - Record physical and virtual index bits
// - Error PC saved on error-class exceptions
// - Error PC is faulting or branch address
// - Exception sets EXL or ERL, return clears EXL only
// - Reset initialises replace index, pinned, status
// - Soft reset and NMI set status bits
// - Cache error vector base and offset
// - Cause written, pending bits kept
// - Return PC saved only if level clear
// - Vector base chosen by boot bit
// - Offsets for refill, wide, cache, other
// - 32-bit mode uses low word
// - Reset class always fixed vector
// - Refill vector chosen by address space
// - Supervisor region uses kernel wide bit
// - Kernel top, wide-only, user region rules
// - Both page pointers loaded on TLB faults
// - Highest priority exception reported only
// - Data exceptions then interrupt lowest
module evu_exception_vector_unit #(
  parameter int TLB_ENTRY_COUNT = 48
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 exc_valid,
  input  wire evu_pkg::evu_req_s    exc_req,
  input  wire evu_pkg::evu_ctx_s    exc_ctx,
  input  wire evu_pkg::evu_cerr_s   cerr_info,
  input  wire logic                 mode32,
  output logic                      redirect_valid,
  output logic      [63:0]          redirect_pc,
  output logic                      kernel_mode
);
  import evu_pkg::*;

  logic [31:0] status_reg;
  logic [31:0] cause_reg;
  logic [63:0] epc_reg;
  logic [63:0] erpc_reg;
  logic [31:0] cfi_reg;
  logic [26:0] ppn_reg;
  logic [26:0] ppw_reg;
  logic [63:0] vec_reg;
  logic [7:0]  replace_reg;
  logic [7:0]  pinned_reg;
  logic        boot_reg;
  evu_kind_e   kind_next;
  logic        is_tlb_any;
  logic [4:0]  code_next;
  logic [63:0] vec_next;
  logic        wr_ok;
  logic        rd_ok;
  logic [31:0] rd_next;
  logic        hit_next;

  // Wide-vector choice for a missing address
  function automatic logic use_wide(input logic [63:0] va,
                                    input logic [31:0] st);
    if (va >= EVU_SSEG_LO)
      use_wide = st[EVU_ST_KX];
    else if (va <= EVU_USEG_HI)
      use_wide = st[EVU_ST_UX];
    else
      use_wide = 1'b1;
  endfunction

  // Priority encode: earlier branch wins, so lower requests are masked
  // without any extra gating. The power-on reset itself is presetn and
  // never passes through here; soft reset and NMI share one class.
  always_comb begin
    kind_next  = EVU_K_NONE;
    code_next  = EVU_EC_INT;
    is_tlb_any = 1'b0;
    // Restart class outranks every fault
    if (exc_req.soft_reset || exc_req.nmi) begin
      kind_next = EVU_K_RESET;
    // Instruction fetch faults, in fetch order
    end else if (exc_req.i_addr_err) begin
      kind_next = EVU_K_GEN;
      code_next = EVU_EC_ADEL;
    end else if (exc_req.i_tlb_refill) begin
      kind_next  = EVU_K_REFILL;
      code_next  = EVU_EC_TLBL;
      is_tlb_any = 1'b1;
    end else if (exc_req.i_tlb_invalid) begin
      kind_next  = EVU_K_GEN;
      code_next  = EVU_EC_TLBL;
      is_tlb_any = 1'b1;
    end else if (exc_req.i_cache_err) begin
      kind_next = EVU_K_CERR;
    end else if (exc_req.i_bus_err) begin
      kind_next = EVU_K_GEN;
      code_next = EVU_EC_IBE;
    // Execution class carries its own code from the pipeline
    end else if (exc_req.exec_exc) begin
      kind_next = EVU_K_GEN;
      code_next = exc_ctx.exec_code;
    // Data side faults, then the interrupt last
    end else if (exc_req.d_addr_err) begin
      kind_next = EVU_K_GEN;
      code_next = exc_ctx.is_store ? EVU_EC_ADES : EVU_EC_ADEL;
    end else if (exc_req.d_tlb_refill) begin
      kind_next  = EVU_K_REFILL;
      code_next  = exc_ctx.is_store ? EVU_EC_TLBS : EVU_EC_TLBL;
      // Load and store misses share one vector, only the code differs
      is_tlb_any = 1'b1;
    end else if (exc_req.d_tlb_invalid) begin
      kind_next  = EVU_K_GEN;
      code_next  = exc_ctx.is_store ? EVU_EC_TLBS : EVU_EC_TLBL;
      is_tlb_any = 1'b1;
    end else if (exc_req.d_tlb_mod) begin
      kind_next  = EVU_K_GEN;
      code_next  = EVU_EC_MOD;
      is_tlb_any = 1'b1;
    end else if (exc_req.d_cache_err) begin
      kind_next = EVU_K_CERR;
    end else if (exc_req.d_bus_err) begin
      kind_next = EVU_K_GEN;
      code_next = EVU_EC_DBE;
    end else if (exc_req.interrupt) begin
      kind_next = EVU_K_GEN;
      code_next = EVU_EC_INT;
    end
  end

  // Vector address for the winning exception
  always_comb begin
    logic [63:0] base;
    base = status_reg[EVU_ST_BEV] ? EVU_BASE_BOOT : EVU_BASE_NORM;
    case (kind_next)
      EVU_K_RESET:
        vec_next = EVU_VEC_RESET;
      EVU_K_CERR:
        vec_next = (status_reg[EVU_ST_BEV] ? EVU_BASE_BOOT : EVU_BASE_CERR)
                   + EVU_OFF_CERR;
      EVU_K_REFILL:
        if (status_reg[EVU_ST_EXL])
          vec_next = base + EVU_OFF_OTHER;
        else if (use_wide(exc_ctx.bad_vaddr, status_reg))
          vec_next = base + EVU_OFF_XREFILL;
        else
          vec_next = base + EVU_OFF_REFILL;
      EVU_K_GEN:
        vec_next = base + EVU_OFF_OTHER;
      default:
        vec_next = vec_reg;
    endcase
    // Narrow mode keeps only the low word of the vector
    if (mode32)
      vec_next = {32'h0000_0000, vec_next[31:0]};
  end

  // An entry needs both the opportunity and a request
  logic take;
  assign take = exc_valid && (kind_next != EVU_K_NONE);
  assign wr_ok = psel && penable && pwrite;
  assign rd_ok = psel && !pwrite;

  // Status: exception entry, return and software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 32'h0000_0000;
      status_reg[EVU_ST_BEV] <= 1'b1;
      status_reg[EVU_ST_ERL] <= 1'b1;
    end else if (take && kind_next == EVU_K_RESET) begin
      status_reg[EVU_ST_BEV] <= 1'b1;
      status_reg[EVU_ST_SR]  <= 1'b1;
      status_reg[EVU_ST_ERL] <= 1'b1;
    end else if (take && kind_next == EVU_K_CERR) begin
      status_reg[EVU_ST_ERL] <= 1'b1;
    end else if (take) begin
      status_reg[EVU_ST_EXL] <= 1'b1;
    end else if (exc_valid && exc_ctx.eret) begin
      status_reg[EVU_ST_EXL] <= 1'b0;
    // Software view: bit 0, exception level, mode, wide-address and boot bits
    end else if (wr_ok && paddr == EVU_ADDR_STATUS) begin
      status_reg <= (status_reg & ~EVU_ST_RW_MASK)
                    | (pwdata & EVU_ST_RW_MASK);
    end
  end

  // Cause: rewritten on general and refill entry, pending lines tracked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_reg <= 32'h0000_0000;
    end else if (take && (kind_next == EVU_K_GEN ||
                          kind_next == EVU_K_REFILL)) begin
      cause_reg <= (cause_reg & EVU_CA_IP_MASK)
                   | {exc_ctx.in_delay_slot, 1'b0, exc_ctx.coproc_num,
                      12'h000, 8'h00, 1'b0, code_next, 2'b00};
    end else if (wr_ok && paddr == EVU_ADDR_CAUSE) begin
      cause_reg <= (cause_reg & ~EVU_CA_SW_MASK) | (pwdata & EVU_CA_SW_MASK);
    end else begin
      // Hardware lines tracked while no general or refill entry or cause write is in flight
      cause_reg[15:10] <= exc_ctx.irq_lines[7:2];
    end
  end

  // Exception return PC: held while already at exception level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      epc_reg <= 64'h0000_0000_0000_0000;
    end else if (take && (kind_next == EVU_K_GEN ||
                          kind_next == EVU_K_REFILL)
                 && !status_reg[EVU_ST_EXL]) begin
      epc_reg <= exc_ctx.pc;
    end else if (wr_ok && paddr == EVU_ADDR_EPC_LO) begin
      epc_reg[31:0] <= pwdata;
    end else if (wr_ok && paddr == EVU_ADDR_EPC_HI) begin
      epc_reg[63:32] <= pwdata;
    end
  end

  // Error return PC: pipeline gives branch address for delay slots
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erpc_reg <= 64'h0000_0000_0000_0000;
      boot_reg <= 1'b1;
    // First edge after reset keeps the power-on restart pc
    end else if (boot_reg) begin
      erpc_reg <= exc_ctx.pc;
      boot_reg <= 1'b0;
    end else if (take && (kind_next == EVU_K_RESET ||
                          kind_next == EVU_K_CERR)) begin
      erpc_reg <= exc_ctx.pc;
    end else if (wr_ok && paddr == EVU_ADDR_ERPC_LO) begin
      erpc_reg[31:0] <= pwdata;
    end else if (wr_ok && paddr == EVU_ADDR_ERPC_HI) begin
      erpc_reg[63:32] <= pwdata;
    end
  end

  // Cache fault info capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfi_reg <= 32'h0000_0000;
    end else if (take && kind_next == EVU_K_CERR) begin
      cfi_reg <= {cerr_info.ref_kind_flag,
                  cerr_info.cache_level_flag,
                  cerr_info.data_field_error,
                  cerr_info.tag_field_error,
                  1'b0,
                  cerr_info.sysbus_error_flag,
                  cerr_info.extra_data_error,
                  cerr_info.store_miss_fill_error,
                  1'b0, 1'b0,
                  cerr_info.phys_index,
                  cerr_info.virt_index_bits,
                  1'b0};
    end
  end

  // Page pointers: separate registers, both loaded on TLB faults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ppn_reg <= 27'h0000000;
      ppw_reg <= 27'h0000000;
    end else if (take && is_tlb_any) begin
      ppn_reg <= exc_ctx.bad_vaddr[39:13];
      ppw_reg <= exc_ctx.bad_vaddr[39:13];
    end
  end

  // TLB replacement index and pinned count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      replace_reg <= 8'(TLB_ENTRY_COUNT - 1);
      pinned_reg  <= 8'h00;
    end else if (wr_ok && paddr == EVU_ADDR_TLBCNT) begin
      pinned_reg <= pwdata[7:0];
    // Free-running step down keeps pinned entries out of reach
    end else if (replace_reg <= pinned_reg) begin
      replace_reg <= 8'(TLB_ENTRY_COUNT - 1);
    end else begin
      replace_reg <= replace_reg - 8'h01;
    end
  end

  // Redirect and mode outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      redirect_valid <= 1'b0;
      redirect_pc    <= EVU_VEC_RESET;
      vec_reg        <= EVU_VEC_RESET;
      kernel_mode    <= 1'b1;
    end else begin
      redirect_valid <= take;
      if (take) begin
        redirect_pc <= vec_next;
        vec_reg     <= vec_next;
      end
      // Entry forces kernel in the same cycle as the redirect; status
      // is set on the same edge but reaches kernel_mode only one cycle later
      kernel_mode <= take || status_reg[EVU_ST_EXL] ||
                     status_reg[EVU_ST_ERL] ||
                     (status_reg[EVU_ST_KSU+1:EVU_ST_KSU] == 2'b00);
    end
  end

  // APB read mux; unmapped reads give zero with an error
  always_comb begin
    hit_next = 1'b1;
    case (paddr)
      EVU_ADDR_CFI:     rd_next = cfi_reg;
      EVU_ADDR_ERPC_LO: rd_next = erpc_reg[31:0];
      EVU_ADDR_ERPC_HI: rd_next = erpc_reg[63:32];
      EVU_ADDR_STATUS:  rd_next = status_reg;
      EVU_ADDR_CAUSE:   rd_next = cause_reg;
      EVU_ADDR_EPC_LO:  rd_next = epc_reg[31:0];
      EVU_ADDR_EPC_HI:  rd_next = epc_reg[63:32];
      EVU_ADDR_VEC_LO:  rd_next = vec_reg[31:0];
      EVU_ADDR_VEC_HI:  rd_next = vec_reg[63:32];
      EVU_ADDR_PPN:     rd_next = {5'h00, ppn_reg};
      EVU_ADDR_PPW:     rd_next = {5'h00, ppw_reg};
      EVU_ADDR_TLBCNT:  rd_next = {16'h0000, replace_reg, pinned_reg};
      default: begin
        rd_next  = 32'h0000_0000;
        hit_next = 1'b0;
      end
    endcase
  end

  // Zero wait state answer registered in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit_next;
      if (rd_ok && !penable)
        prdata <= rd_next;
    end
  end
endmodule
`default_nettype wire

// file: verification/evu_vec_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module evu_vec_asserts (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              exc_valid,
  input wire evu_pkg::evu_req_s exc_req,
  input wire logic              redirect_valid,
  input wire logic [63:0]       redirect_pc,
  input wire logic              kernel_mode
);
  import evu_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Exception entry: one pulse per request, none without one
  a_redir_follows: assert property (exc_valid && exc_req != '0
    |=> redirect_valid) else $error("no redirect after request");
  a_no_spurious: assert property (!(exc_valid && exc_req != '0)
    |=> !redirect_valid) else $error("redirect without request");
  a_reset_vec: assert property (exc_valid && (exc_req.soft_reset
    || exc_req.nmi) |=> redirect_pc[31:0] == EVU_VEC_RESET[31:0])
    else $error("soft reset class vector wrong");
  // Low bits of the vector hold the offset whatever the base
  a_cerr_offset: assert property (exc_valid && exc_req.i_cache_err
    && exc_req[14:10] == '0 |=> redirect_pc[8:0] == 9'h100)
    else $error("cache error offset wrong");
  a_other_offset: assert property (exc_valid && exc_req.exec_exc
    && exc_req[14:8] == '0 |=> redirect_pc[8:0] == 9'h180)
    else $error("general offset wrong");
  a_kernel_entry: assert property (redirect_valid |-> kernel_mode)
    else $error("not kernel mode on entry");
  // Register bus answers: zero wait, one cycle, error only with ready
  a_setup_answer: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");

  c_nmi: cover property (exc_valid && exc_req.nmi);
  c_refill: cover property (exc_valid && exc_req.d_tlb_refill);
  c_bus_err: cover property (pslverr);
endmodule

bind evu_exception_vector_unit evu_vec_asserts i_evu_vec_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .exc_valid(exc_valid),
  .exc_req(exc_req), .redirect_valid(redirect_valid),
  .redirect_pc(redirect_pc), .kernel_mode(kernel_mode));
`default_nettype wire

// file: verification/evu_pipe_model.sv
`timescale 1ns/10ps
`default_nettype none
module evu_pipe_model #(
  parameter logic [63:0] BOOT_PC = 64'h0000_0000_0040_1230
) (
  input  wire logic               pclk,
  output var  logic               exc_valid,
  output var  evu_pkg::evu_req_s  exc_req,
  output var  evu_pkg::evu_ctx_s  exc_ctx,
  output var  evu_pkg::evu_cerr_s cerr_info
);
  import evu_pkg::*;
  // Quiet at start; pc held so the restart copy sees it
  initial begin
    exc_valid = 1'b0;
    exc_req = '0;
    exc_ctx = '0;
    exc_ctx.pc = BOOT_PC;
    cerr_info = '0;
  end

  // One cycle of request; lines invert after so stale data never looks valid
  task automatic raise(input evu_req_s r, input evu_ctx_s c,
                       input evu_cerr_s e);
    @(posedge pclk);
    exc_valid <= 1'b1;
    exc_req <= r;
    exc_ctx <= c;
    cerr_info <= e;
    @(posedge pclk);
    exc_valid <= 1'b0;
    exc_req <= ~r;
    exc_ctx <= ~c;
    cerr_info <= ~e;
  endtask
endmodule
`default_nettype wire

// file: verification/evu_exception_vector_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module evu_exception_vector_unit_tb;
  import evu_pkg::*;
  localparam int          TLBN = 16;
  localparam logic [63:0] PC0  = 64'h0000_0000_0040_1230;
  int          n_cyc   = 0;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        mode32  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, exc_valid, redirect_valid, kernel_mode;
  logic [63:0] redirect_pc;
  evu_req_s    exc_req;
  evu_ctx_s    exc_ctx;
  evu_cerr_s   cerr_info;
  int          n_errors = 0;
  int          n_checks = 0;

  // 250 MHz clock
  always #2 pclk = ~pclk;

  // Cycles since reset release, for the free-running replacement index
  always @(posedge pclk) n_cyc <= presetn ? n_cyc + 1 : 0;

  evu_exception_vector_unit #(.TLB_ENTRY_COUNT(TLBN))
    i_evu_exception_vector_unit (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .exc_valid(exc_valid), .exc_req(exc_req),
    .exc_ctx(exc_ctx), .cerr_info(cerr_info), .mode32(mode32),
    .redirect_valid(redirect_valid), .redirect_pc(redirect_pc),
    .kernel_mode(kernel_mode));

  evu_pipe_model #(.BOOT_PC(PC0)) i_evu_pipe_model (.pclk(pclk),
    .exc_valid(exc_valid), .exc_req(exc_req), .exc_ctx(exc_ctx),
    .cerr_info(cerr_info));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Bus cycle: hold the request until ready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) n_errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  // 64-bit registers are read low word first
  task automatic rd64(input logic [11:0] a, output logic [63:0] q);
    rd(a, q[31:0]);
    rd(a + 12'h004, q[63:32]);
  endtask

  // Raise one request and check the answer in the following cycle
  task automatic exc(input evu_req_s r, input evu_ctx_s c,
                     input evu_cerr_s e, input logic [63:0] v);
    i_evu_pipe_model.raise(r, c, e);
    @(negedge pclk);
    chk({63'h0, redirect_valid}, 64'h1);
    chk({63'h0, kernel_mode}, 64'h1);
    chk(mode32 ? {32'h0, redirect_pc[31:0]} : redirect_pc,
        mode32 ? {32'h0, v[31:0]} : v);
  endtask

  // Index of the highest set request, -1 when none
  function automatic int top_req(input evu_req_s r);
    top_req = -1;
    for (int i = 0; i < 15; i++)
      if (r[i]) top_req = i;
  endfunction

  // Highest set request wins; refill picks narrow or wide by region
  function automatic logic [63:0] exp_vec(input evu_req_s r,
      input logic [63:0] va, input logic ux, input logic kx,
      input logic boot_vector_select);
    int          h;
    logic        w;
    logic [63:0] b;
    h = top_req(r);
    w = (va >= EVU_SSEG_LO) ? kx
      : (va <= EVU_USEG_HI) ? ux : 1'b1;
    b = boot_vector_select ? EVU_BASE_BOOT : EVU_BASE_NORM;
    if (h >= 13) return EVU_VEC_RESET;
    if (h == 11 || h == 5) return b + (w ? EVU_OFF_XREFILL : EVU_OFF_REFILL);
    if (h == 9 || h == 2)
      return (boot_vector_select ? EVU_BASE_BOOT : EVU_BASE_CERR) + EVU_OFF_CERR;
    return b + EVU_OFF_OTHER;
  endfunction

  // Main sequence
  initial begin
    logic [31:0] q;
    logic [63:0] q64, pc0;
    logic        e;
    logic [3:0]  xb;
    logic [26:0] pp;
    evu_req_s    r;
    evu_ctx_s    c;
    evu_cerr_s   ce;
    void'($urandom(32'h5d2e0b13));
    pp = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(redirect_pc, EVU_VEC_RESET);
    rd(EVU_ADDR_STATUS, q);
    chk({61'h0, q[22], q[20], q[2]}, 64'h5);
    rd(EVU_ADDR_TLBCNT, q);
    // Index starts at the top and steps down once a cycle, wrapping at zero
    chk({48'h0, q[15:0]},
        {48'h0, 8'(TLBN - 1 - (n_cyc - 1) % TLBN), 8'h00});
    rd64(EVU_ADDR_ERPC_LO, q64);
    chk(q64, PC0);
    apb(1'b0, 12'h200, 32'h0, q, e);
    chk({31'h0, e, q}, {31'h0, 1'b1, 32'h0});
    // Boot vector off; second general entry leaves the return pc alone
    wr(EVU_ADDR_STATUS, 32'h0);
    c = '0;
    ce = '0;
    r = '0;
    r.exec_exc = 1'b1;
    for (int k = 0; k < 2; k++) begin
      c.pc = {$urandom, $urandom};
      c.in_delay_slot = 1'($urandom);
      c.coproc_num = 2'($urandom);
      c.exec_code = 5'($urandom_range(8, 15));
      if (k == 0) pc0 = c.pc;
      exc(r, c, ce, EVU_BASE_NORM + EVU_OFF_OTHER);
      rd(EVU_ADDR_CAUSE, q);
      chk({56'h0, q[31], q[29:28], q[6:2]},
          {56'h0, c.in_delay_slot, c.coproc_num, c.exec_code});
      rd64(EVU_ADDR_EPC_LO, q64);
      chk(q64, pc0);
    end
    rd(EVU_ADDR_STATUS, q);
    chk({63'h0, q[1]}, 64'h1);
    r = '0;
    c.eret = 1'b1;
    i_evu_pipe_model.raise(r, c, ce);
    @(negedge pclk);
    chk({63'h0, redirect_valid}, 64'h0);
    rd(EVU_ADDR_STATUS, q);
    chk({63'h0, q[1]}, 64'h0);
    // Cache error fills the fault record and the error pc
    c.eret = 1'b0;
    r.i_cache_err = 1'b1;
    ce = 28'($urandom);
    c.pc = {$urandom, $urandom};
    exc(r, c, ce, EVU_BASE_CERR + EVU_OFF_CERR);
    rd(EVU_ADDR_CFI, q);
    chk({32'h0, q}, {32'h0, ce[27:24], 1'b0, ce[23:21], 2'b0, ce[20:0],
        1'b0});
    rd64(EVU_ADDR_ERPC_LO, q64);
    chk(q64, c.pc);
    for (int k = 0; k < 2; k++) begin
      r = '0;
      r.soft_reset = (k == 0);
      r.nmi = (k == 1);
      c.pc = {$urandom, $urandom};
      exc(r, c, ce, EVU_VEC_RESET);
      rd(EVU_ADDR_STATUS, q);
      chk({61'h0, q[22], q[20], q[2]}, 64'h7);
      rd64(EVU_ADDR_ERPC_LO, q64);
      chk(q64, c.pc);
    end
    // Random mixes of requests, regions and wide bits
    for (int k = 0; k < 60; k++) begin
      xb = 4'($urandom);
      wr(EVU_ADDR_STATUS, {9'h000, xb[3], 14'h0000, xb[2:0], 5'h00});
      r = 15'($urandom & $urandom);
      if ($urandom_range(0, 3) != 0) r[14:13] = 2'b00;
      if (r == '0) r.interrupt = 1'b1;
      c.pc = {$urandom, $urandom};
      case ($urandom_range(0, 3))
        0: c.bad_vaddr = 64'h0;
        1: c.bad_vaddr = EVU_SSEG_LO;
        2: c.bad_vaddr = EVU_KSEG3_LO;
        default: c.bad_vaddr = 64'h0000_0001_0000_0000;
      endcase
      c.bad_vaddr = c.bad_vaddr | {32'h0, $urandom & 32'h0FFF_FFF8};
      mode32 <= 1'($urandom);
      repeat ($urandom_range(0, 2)) @(posedge pclk);
      exc(r, c, ce, exp_vec(r, c.bad_vaddr, xb[0], xb[2], xb[3]));
      // Both page pointers hold the last TLB fault's page pair
      if (top_req(r) inside {3, 4, 5, 10, 11}) pp = c.bad_vaddr[39:13];
      rd(EVU_ADDR_PPN, q);
      chk({32'h0, q}, {37'h0, pp});
      rd(EVU_ADDR_PPW, q);
      chk({32'h0, q}, {37'h0, pp});
    end
    conclude();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    conclude();
  end
endmodule
`default_nettype wire
